/* rtl/fpir_core.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - select-low bursts 7..33 clocks end xip
// - ending xip never resets or aborts work
// - below threshold: held reset, silent
// - power-up accepts only status reads
// - standby clears wel, wip, lock bits
// - ready bit zero while program/erase runs
// - accessible within 300 us of supply
// - ready then uses configured protocol
// - interrupted erase stretches power-up time
// - power-up: hold on, reset ignored, default drive
// - step one: six bursts, lines high
// - loss recovery: 8 clocks, extended no xip
// - rescue: 16 clocks, extended single line
// - rescue restores interface, core untouched
// - confirmation bit is line zero, first dummy
// - xip end sets xip-disable bit to one
module fpir_core
   import fpir_pkg::*;
#(
   parameter int unsigned ACCESS_CYC = PWRUP_ACCESS_CYC, // power-up access time in cycles
   parameter int unsigned REC4_CYC   = RECOV_4K_CYC,     // extended time, 4KB recovery
   parameter int unsigned REC32_CYC  = RECOV_32K_CYC     // extended time, 32KB recovery
)(
   input  wire logic       clk_in,            // core clock
   input  wire logic       rst_in,            // synchronous reset, high
   input  wire logic       por_ok_in,         // supply above reset threshold, async pin
   input  wire logic       erase_intr_4k_in,  // interrupted 4KB erase to recover
   input  wire logic       erase_intr_32k_in, // interrupted 32KB erase to recover
   input  wire logic       pe_busy_in,        // program or erase running
   input  wire logic [1:0] nv_proto_in,       // protocol from nonvolatile config
   input  wire logic       nv_xip_in,         // boot in xip from nonvolatile config
   input  wire logic       sclk_in,           // link clock
   input  wire logic       cs_n_in,           // chip select, low active
   input  wire logic       d0_in,             // serial line zero
   input  wire logic       d3_in,             // serial line three
   output logic            ready_out,         // power-up complete
   output logic            pwrup_out,         // in power-up phase
   output logic            cmd_allowed_out,   // last opcode allowed now
   output logic            ctrl_ready_out,    // controller-ready flag bit
   output logic            wel_out,           // write-enable latch
   output logic            wip_out,           // write in progress
   output logic [1:0]      lock_out,          // write-lock, lock-down
   output logic            hold_en_out,       // hold function active
   output logic            rst_pin_en_out,    // reset input honoured
   output logic            drive_default_out, // output drive forced to default
   output logic            xip_out,           // execute-in-place active
   output logic            xip_dis_out,       // volatile xip-disable bit
   output logic [1:0]      proto_out,         // active protocol
   output logic            iface_reset_out    // one-cycle interface restore pulse
);
   fpir_win_if win ();          // crossing carrier
   fpir_state_t state_r;        // sequencer state
   logic [31:0] cnt_r;          // power-up timer
   logic [31:0] limit_r;        // chosen access time
   logic        por_s1_r;       // supply sync stage 1
   logic        por_s2_r;       // supply sync stage 2
   logic        tg_s1_r;        // select sync stage 1
   logic        tg_s2_r;        // select sync stage 2
   logic        tg_s3_r;        // select history
   logic        win_evt;        // a window finished
   logic [2:0]  step_r;         // step-one bursts matched
   logic        busy_s1_r;      // busy sync stage 1
   logic        busy_s2_r;      // busy sync stage 2
   logic        xs1_r;          // power-up phase was active last cycle
   logic [31:0] pw_cyc_r;       // checking aid: cycles spent in power-up

   // link-side counter
   fpir_link u_link (
      .sclk_in     (sclk_in),
      .cs_n_in     (cs_n_in),
      .d0_in       (d0_in),
      .d3_in       (d3_in),
      .xip_mode_in (xip_out),
      .win         (win.link)
   );

   // two-flop synchronisers for pin levels and the window toggle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         por_s1_r  <= 1'b0;
         por_s2_r  <= 1'b0;
         // select idles high, so no false window end follows reset
         tg_s1_r   <= 1'b1;
         tg_s2_r   <= 1'b1;
         tg_s3_r   <= 1'b1;
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
      end else begin
         por_s1_r  <= por_ok_in;
         por_s2_r  <= por_s1_r;
         tg_s1_r   <= win.tgl;
         tg_s2_r   <= tg_s1_r;
         tg_s3_r   <= tg_s2_r;
         busy_s1_r <= pe_busy_in;
         busy_s2_r <= busy_s1_r;
      end
   end
   assign win_evt = tg_s2_r & ~tg_s3_r; // select rose: window closed, its data steady

   // power-up sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in || !por_s2_r) begin
         state_r <= FPIR_POR;
         cnt_r   <= 32'h0000_0000;
         limit_r <= 32'h0000_0000;
      end else begin
         unique case (state_r)
            FPIR_POR: begin
               state_r <= FPIR_PWRUP;
               cnt_r   <= 32'h0000_0000;
               // interrupted erase recovery stretches the access time
               if (erase_intr_32k_in)     limit_r <= REC32_CYC;
               else if (erase_intr_4k_in) limit_r <= REC4_CYC;
               else                       limit_r <= ACCESS_CYC;
            end
            FPIR_PWRUP: begin
               cnt_r <= cnt_r + 32'h0000_0001;
               if (cnt_r + 32'h0000_0001 >= limit_r) state_r <= FPIR_STANDBY;
            end
            FPIR_STANDBY: begin
               state_r <= FPIR_STANDBY;
            end
         endcase
      end
   end

   assign ready_out         = (state_r == FPIR_STANDBY);
   assign pwrup_out         = (state_r == FPIR_PWRUP);
   // during power-up hold is on, reset ignored, drive default
   assign hold_en_out       = (state_r != FPIR_STANDBY) || 1'b1;
   assign rst_pin_en_out    = (state_r == FPIR_STANDBY);
   assign drive_default_out = (state_r != FPIR_STANDBY);

   // opcode filter: power-up allows only the two status reads
   always_ff @(posedge clk_in) begin
      if (rst_in || state_r == FPIR_POR || !por_s2_r) begin
         cmd_allowed_out <= 1'b0;
      end else if (win_evt) begin
         if (state_r == FPIR_PWRUP)
            cmd_allowed_out <= (win.opcode == OP_READ_STATUS) ||
                               (win.opcode == OP_READ_FLAG);
         else
            cmd_allowed_out <= 1'b1;
      end
   end

   // standby status bits and controller-ready flag
   always_ff @(posedge clk_in) begin
      if (rst_in || state_r != FPIR_STANDBY) begin
         wel_out        <= 1'b0;
         wip_out        <= 1'b0;
         lock_out       <= 2'h0;
         ctrl_ready_out <= 1'b0;
      end else begin
         wip_out        <= busy_s2_r;
         ctrl_ready_out <= ~busy_s2_r;
      end
   end

   // protocol, xip and recovery bursts
   always_ff @(posedge clk_in) begin
      if (rst_in || state_r == FPIR_POR) begin
         proto_out       <= PROTO_EXT;
         xip_out         <= 1'b0;
         xip_dis_out     <= 1'b1;
         step_r          <= 3'h0;
         iface_reset_out <= 1'b0;
      end else begin
         iface_reset_out <= 1'b0;
         if (state_r == FPIR_PWRUP) begin
            proto_out <= PROTO_EXT;
            xip_out   <= 1'b0;
         end else if (state_r == FPIR_STANDBY && xs1_r) begin
            // first standby cycle: take up configured protocol and boot mode
            proto_out   <= nv_proto_in;
            xip_out     <= nv_xip_in;
            xip_dis_out <= ~nv_xip_in;
         end
         if (state_r == FPIR_STANDBY && win_evt) begin
            // xip end: xip clears and the disable bit sets, no reset, work continues
            if (xip_out && win.xip_term) begin
               xip_out     <= 1'b0;
               xip_dis_out <= 1'b1;
            end
            if (win.all_high && step_r < STEP1_BURSTS &&
                win.count == fpir_step1_len(step_r)) begin
               step_r  <= step_r + 3'h1;
               xip_out <= 1'b0;
               xip_dis_out <= 1'b1;
            end else if (win.all_high && step_r == STEP1_BURSTS &&
                         win.count == BURST_PLR) begin
               proto_out <= PROTO_EXT;
               xip_out   <= 1'b0;
               step_r    <= 3'h0;
            end else if (win.all_high && step_r == STEP1_BURSTS &&
                         win.count == BURST_RESCUE) begin
               proto_out       <= PROTO_EXT;
               xip_out         <= 1'b0;
               iface_reset_out <= 1'b1;
               step_r          <= 3'h0;
            end else if (!(win.all_high && step_r < STEP1_BURSTS &&
                           win.count == fpir_step1_len(step_r))) begin
               step_r <= 3'h0;
            end
         end
      end
   end

   // marks the first standby cycle, where the configured mode is taken up
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         xs1_r <= 1'b0;
      end else begin
         xs1_r <= (state_r == FPIR_PWRUP);
      end
   end

   // checking aid: length of the current power-up phase
   always_ff @(posedge clk_in) begin
      if (rst_in || !pwrup_out) begin
         pw_cyc_r <= 32'h0000_0000;
      end else begin
         pw_cyc_r <= pw_cyc_r + 32'h0000_0001;
      end
   end

   // ready never comes before the access time has run
   a_ready_timing: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(ready_out) |-> $past(state_r) == FPIR_PWRUP)
      else $error("ready before power-up end");
   // status bits clear in standby entry
   a_standby_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(ready_out) |=> !wel_out && lock_out == 2'h0)
      else $error("standby bits not clear");
   // power-up keeps reset pin off and drive default
   a_pwrup_pins: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out |-> !rst_pin_en_out && drive_default_out && hold_en_out)
      else $error("power-up pin state wrong");
   // ready flag opposes busy three cycles later
   a_ctrl_ready: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && $past(ready_out) && busy_s2_r |=> !ctrl_ready_out)
      else $error("ready flag set while busy");
   // below threshold nothing is allowed
   a_por_silent: assert property (@(posedge clk_in) disable iff (rst_in)
      !por_s2_r |=> !cmd_allowed_out && !ready_out)
      else $error("response below threshold");
   // rescue pulse leaves extended protocol
   a_rescue_proto: assert property (@(posedge clk_in) disable iff (rst_in)
      iface_reset_out |-> proto_out == PROTO_EXT && !xip_out)
      else $error("rescue left wrong protocol");
   // xip end sets the disable bit
   a_xip_disable: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(xip_out) && ready_out |-> xip_dis_out)
      else $error("xip disable not set");
   // power-up only permits status reads
   a_pwrup_cmds: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out && win_evt && win.opcode == OP_FAST_READ |=> !cmd_allowed_out)
      else $error("command accepted in power-up");
   // power-up never outlasts the longest recovery time
   a_pwrup_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out |-> pw_cyc_r < REC32_CYC)
      else $error("power-up longer than recovery limit");
   // with no erase to recover, power-up ends within the access time
   a_pwrup_normal: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out && !erase_intr_4k_in && !erase_intr_32k_in |-> pw_cyc_r < ACCESS_CYC)
      else $error("power-up longer than access time");
   // first standby takes up the configured protocol and boot mode
   a_boot_proto: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(ready_out) |=> proto_out == nv_proto_in && xip_out == nv_xip_in)
      else $error("configured mode not taken up");
   // ready flag set when nothing runs
   a_ctrl_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && $past(ready_out) && !busy_s2_r |=> ctrl_ready_out)
      else $error("ready flag clear while idle");
   // a window with a line low restarts step one
   a_window_refused: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && win_evt && !win.all_high |=> step_r == 3'h0)
      else $error("spoiled window kept step count");
   // rescue only after all six step-one bursts
   a_rescue_order: assert property (@(posedge clk_in) disable iff (rst_in)
      iface_reset_out |-> $past(step_r) == STEP1_BURSTS)
      else $error("rescue out of order");
   // rescue leaves the core state and running work alone
   a_rescue_core: assert property (@(posedge clk_in) disable iff (rst_in)
      iface_reset_out |-> ready_out && wip_out == $past(busy_s2_r))
      else $error("rescue disturbed core");
   // loss recovery second step lands in extended protocol
   a_loss_proto: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && win_evt && win.all_high && step_r == STEP1_BURSTS && win.count == BURST_PLR
      |=> proto_out == PROTO_EXT && !xip_out)
      else $error("loss recovery left wrong protocol");
   // a finished window never resets the device
   a_window_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && win_evt && por_s2_r |=> ready_out)
      else $error("window reset the device");
   // a seven-clock burst ends xip and sets the disable bit
   a_xip_burst_end: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_out && win_evt && win.all_high && step_r == 3'h0 && win.count == BURST_7
      |=> !xip_out && xip_dis_out)
      else $error("burst did not end xip");
   // power-up runs single-line extended protocol
   a_pwrup_ext: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out |-> proto_out == PROTO_EXT && !xip_out)
      else $error("power-up not in extended protocol");
   // power-up accepts the two status reads
   a_pwrup_status: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrup_out && por_s2_r && win_evt && (win.opcode == OP_READ_STATUS || win.opcode == OP_READ_FLAG)
      |=> cmd_allowed_out)
      else $error("status read refused in power-up");
   // standby entry has no write in progress
   a_standby_wip: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(ready_out) |-> !wip_out)
      else $error("write in progress at standby");
   // below threshold the sequencer and interface stay idle
   a_por_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      !por_s2_r && !$past(por_s2_r) |=> !pwrup_out && !iface_reset_out && !xip_out)
      else $error("activity below threshold");
endmodule

/* rtl/fpir_link.sv */
`timescale 1ns/1ns
// link-side window counter, clocked by the serial clock
module fpir_link
   import fpir_pkg::*;
(
   input  wire logic sclk_in,           // link clock
   input  wire logic cs_n_in,           // chip select, low active
   input  wire logic d0_in,             // serial line zero
   input  wire logic d3_in,             // serial line three
   input  wire logic xip_mode_in,       // xip level from the core clock domain
   fpir_win_if.link  win
);
   logic [5:0] cnt_r;    // edges within current window
   logic       high_r;   // lines stayed high so far
   logic       term_r;   // confirmation bit seen as 1
   logic [7:0] op_r;     // shifted first byte
   logic       xm_s1_r;  // xip level, first link-side stage
   logic       xm_s2_r;  // xip level, second link-side stage

   // count edges; a new window starts on the first edge after deselect
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         cnt_r  <= 6'h00;
         high_r <= 1'b1;
         term_r <= 1'b0;
         op_r   <= 8'h00;
      end else begin
         if (cnt_r != COUNT_MAX) cnt_r <= cnt_r + 6'h01;
         high_r <= high_r & d0_in & d3_in;
         if (cnt_r < 6'h08) op_r <= {op_r[6:0], d0_in};
         // confirmation bit: line zero on the first dummy edge
         if (cnt_r == (xm_s2_r ? 6'h18 : 6'h20) && d0_in) term_r <= 1'b1;
      end
   end

   // window end is seen on deselect rise; data held till the next window closes
   always_ff @(posedge cs_n_in) begin
      win.count     <= cnt_r;
      win.all_high  <= high_r;
      win.xip_term  <= term_r;
      win.opcode    <= op_r;
   end
   // the core synchronises the select level itself and reads the window on its rise
   assign win.tgl = cs_n_in;

   // xip level crosses on link edges; it only changes between windows, long before the dummy edge
   always_ff @(posedge sclk_in) begin
      xm_s1_r <= xip_mode_in;
      xm_s2_r <= xm_s1_r;
   end
endmodule

/* rtl/fpir_pkg.sv */
package fpir_pkg;
   // power-up access time, microseconds, and the clock rate
   localparam int unsigned CLK_MHZ            = 100;
   localparam int unsigned PWRUP_ACCESS_US    = 300;
   localparam int unsigned PWRUP_ACCESS_CYC   = PWRUP_ACCESS_US * CLK_MHZ;
   // extended power-up time after interrupted sub-sector erase, microseconds
   localparam int unsigned RECOV_4K_US        = 4500;
   localparam int unsigned RECOV_32K_US       = 36000;
   localparam int unsigned RECOV_4K_CYC       = RECOV_4K_US * CLK_MHZ;
   localparam int unsigned RECOV_32K_CYC      = RECOV_32K_US * CLK_MHZ;
   // burst lengths, in link clock edges within one select-low window
   localparam logic [5:0]  BURST_7            = 6'h07;
   localparam logic [5:0]  BURST_9            = 6'h09;
   localparam logic [5:0]  BURST_13           = 6'h0D;
   localparam logic [5:0]  BURST_17           = 6'h11;
   localparam logic [5:0]  BURST_25           = 6'h19;
   localparam logic [5:0]  BURST_33           = 6'h21;
   localparam logic [5:0]  BURST_PLR          = 6'h08;
   localparam logic [5:0]  BURST_RESCUE       = 6'h10;
   localparam logic [5:0]  COUNT_MAX          = 6'h3F;
   // number of bursts in the first recovery step
   localparam logic [2:0]  STEP1_BURSTS       = 3'h6;
   // protocol codes
   localparam logic [1:0]  PROTO_EXT          = 2'h0;
   // fast read, status read and flag read opcodes, and the fast read dummy position (single line)
   localparam logic [7:0]  OP_FAST_READ       = 8'h0B;
   localparam logic [7:0]  OP_READ_STATUS     = 8'h05;
   localparam logic [7:0]  OP_READ_FLAG       = 8'h70;
   localparam logic [5:0]  FR_DUMMY_EDGE      = 6'h21;
   // sequencer states
   typedef enum logic [1:0] {FPIR_POR, FPIR_PWRUP, FPIR_STANDBY} fpir_state_t;
   // expected step-one burst by index
   function automatic logic [5:0] fpir_step1_len(input logic [2:0] idx);
      case (idx)
         3'h0:    fpir_step1_len = BURST_7;
         3'h1:    fpir_step1_len = BURST_9;
         3'h2:    fpir_step1_len = BURST_13;
         3'h3:    fpir_step1_len = BURST_17;
         3'h4:    fpir_step1_len = BURST_25;
         default: fpir_step1_len = BURST_33;
      endcase
   endfunction
endpackage

/* rtl/fpir_win_if.sv */
`timescale 1ns/1ns
// carries a finished select-low window from link domain to core domain
interface fpir_win_if;
   logic       tgl;      // select level: rises as a window closes
   logic [5:0] count;    // link clock edges seen in the window
   logic       all_high; // data lines 0 and 3 high throughout
   logic       xip_term; // confirmation bit 1 seen on a fast read
   logic [7:0] opcode;   // first byte of the window
   modport link (output tgl, count, all_high, xip_term, opcode);
   modport core (input tgl, count, all_high, xip_term, opcode);
endinterface

/* sim/flash_powerup_and_interface_rescue_tb_top.sv */
`timescale 1ns/1ns
// bench: driver notes expectations in a queue, a monitor compares them
module flash_powerup_and_interface_rescue_tb_top;
   import fpir_pkg::*;
   localparam int unsigned ACC   = 300;  // shortened power-up access time
   localparam int unsigned REC4  = 600;  // shortened 4KB recovery time
   localparam int unsigned REC32 = 900;  // shortened 32KB recovery time
   localparam logic [7:0]  NV_WRITE_OP = 8'hA5; // arbitrary stand-in for the configuration write
   localparam logic [5:0]  LENS [6] = '{BURST_7, BURST_9, BURST_13, BURST_17, BURST_25, BURST_33};
   typedef struct packed {logic [15:0] e; logic [15:0] m;} fpir_note_t;
   logic        clk_in, rst_in, por_ok, e4, busy, nv_xip, b;
   logic [1:0]  nv_proto, lock, proto;
   logic        sclk, cs_n, d0, d3;
   logic        ready, pwrup, cmd_ok, ctrl_rdy, wel, wip, hold, rstpin, drvdef, execute_in_place, xipdis, ifrst;
   logic [15:0] stat;      // packed view of all status outputs
   fpir_note_t  note_q[$]; // pending expectations
   fpir_note_t  cur;       // expectation under comparison
   logic [15:0] pulse_q[$];
   int          n_errors, comparisons, pulse_cnt, cyc, seed, r, i, p;
   event        sample_ev;
   assign stat = {1'b0, ready, pwrup, cmd_ok, ctrl_rdy, wel, wip, lock, hold, rstpin, drvdef, execute_in_place, xipdis, proto};
   fpir_core #(.ACCESS_CYC(ACC), .REC4_CYC(REC4), .REC32_CYC(REC32)) i_fpir_core (
      .clk_in(clk_in), .rst_in(rst_in), .por_ok_in(por_ok), .erase_intr_4k_in(e4),
      .erase_intr_32k_in(1'b0), .pe_busy_in(busy), .nv_proto_in(nv_proto), .nv_xip_in(nv_xip),
      .sclk_in(sclk), .cs_n_in(cs_n), .d0_in(d0), .d3_in(d3), .ready_out(ready), .pwrup_out(pwrup),
      .cmd_allowed_out(cmd_ok), .ctrl_ready_out(ctrl_rdy), .wel_out(wel), .wip_out(wip),
      .lock_out(lock), .hold_en_out(hold), .rst_pin_en_out(rstpin), .drive_default_out(drvdef),
      .xip_out(execute_in_place), .xip_dis_out(xipdis), .proto_out(proto), .iface_reset_out(ifrst));
   fpir_host i_fpir_host (.sclk_out(sclk), .cs_n_out(cs_n), .d0_out(d0), .d3_out(d3));
   // core clock, 10 ns
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // one comparison, counted, reported on mismatch
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // record an expectation and ask the monitor to take it
   task automatic note(input logic [15:0] e, input logic [15:0] m);
      note_q.push_back('{e: e, m: m});
      @(negedge clk_in);
      ->sample_ev;
   endtask
   // monitor: oldest expectation against the settled outputs
   always begin
      @(sample_ev);
      cur = note_q.pop_front();
      check(stat & cur.m, cur.e & cur.m);
   end
   // monitor: counts each interface restore pulse; one with a queued expectation must leave the core running
   always @(posedge clk_in) begin
      if (ifrst === 1'b1) begin
         pulse_cnt++;
         if (pulse_q.size() > 0) check({15'h0, ready}, pulse_q.pop_front());
      end
   end
   // hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // reset held six cycles, nonvolatile xip boot chosen meanwhile
   task automatic do_reset(input logic xipv);
      rst_in <= 1'b1;
      nv_xip <= xipv;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
   endtask
   // bounded wait for power-up to finish
   task automatic wait_ready(input int lim);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < lim) begin
         @(negedge clk_in);
         k++;
      end
      check({15'h0, ready}, 16'h0001);
   endtask
   // junk window, six step-one bursts (one may be spoiled), then the second step
   task automatic recover(input int bad, input logic [5:0] last, input logic d3bad);
      int k;
      logic [5:0] len;
      i_fpir_host.frame(BURST_7, 8'hFF, 1'b0);
      for (k = 0; k < 6; k++) begin
         len = (k == bad && !d3bad) ? LENS[k] + 6'h01 : LENS[k];
         i_fpir_host.frame(len, 8'hFF, !(k == bad && d3bad));
      end
      i_fpir_host.frame(last, 8'hFF, 1'b1);
      i_fpir_host.frame(6'h08, NV_WRITE_OP, 1'b1);
   endtask
   // main sequence
   initial begin
      seed = 65;
      rst_in = 1'b1;
      por_ok = 1'b1;
      e4 = 1'b0;
      busy = 1'b0;
      nv_xip = 1'b0;
      r = $random(seed);
      nv_proto = r[1:0];
      @(posedge clk_in);
      do_reset(1'b0);
      repeat (3) @(posedge clk_in);
      note(16'h2050, 16'h6070);
      i_fpir_host.frame(6'h08, OP_READ_STATUS, 1'b1);
      note(16'h1000, 16'h1000);
      i_fpir_host.frame(6'h08, OP_FAST_READ, 1'b1);
      note(16'h0000, 16'h1000);
      i_fpir_host.frame(6'h08, OP_READ_FLAG, 1'b1);
      note(16'h1000, 16'h1000);
      wait_ready(ACC + 20);
      note(16'h4060, 16'h67F8);
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         b = r[0];
         @(posedge clk_in);
         busy <= b;
         repeat (5) @(posedge clk_in);
         note(b ? 16'h0200 : 16'h0800, 16'h0A00);
      end
      $display("test power_up done");
      @(posedge clk_in);
      do_reset(1'b1);
      wait_ready(ACC + 20);
      note(16'h4008, 16'h4008);
      @(posedge clk_in);
      busy <= 1'b1;
      i_fpir_host.frame(BURST_7, 8'hFF, 1'b1);
      note(16'h4004, 16'h480C);
      i_fpir_host.soft_reset();
      @(posedge clk_in);
      busy <= 1'b0;
      $display("test xip_end done");
      pulse_q.push_back(16'h0001);
      p = pulse_cnt;
      recover(9, BURST_RESCUE, 1'b0);
      check(16'(pulse_cnt - p), 16'h0001);
      p = pulse_cnt;
      recover(2, BURST_RESCUE, 1'b1);
      recover(1, BURST_RESCUE, 1'b0);
      check(16'(pulse_cnt - p), 16'h0000);
      $display("test rescue done");
      @(posedge clk_in);
      e4 <= 1'b1;
      do_reset(1'b1);
      repeat (ACC + 20) @(posedge clk_in);
      check({15'h0, ready}, 16'h0000);
      wait_ready(REC4);
      @(posedge clk_in);
      e4 <= 1'b0;
      recover(9, BURST_PLR, 1'b0);
      note({2'h1, 12'h000, PROTO_EXT}, 16'h400B);
      $display("test loss_recovery done");
      @(posedge clk_in);
      por_ok <= 1'b0;
      repeat (5) @(posedge clk_in);
      note(16'h0000, 16'h5620);
      $display("test supply_loss done");
      conclude();
   end
endmodule

/* sim/fpir_host.sv */
`timescale 1ns/1ns
// host controller model: drives select, serial clock and data lines 0 and 3
module fpir_host (
   output logic sclk_out,   // link clock, runs only inside a window
   output logic cs_n_out,   // chip select, low active
   output logic d0_out,     // serial line zero
   output logic d3_out      // serial line three
);
   // select stays high from power-on so the device is never picked during the ramp
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      d0_out   = 1'b1;
      d3_out   = 1'b1;
   end
   // one select-low window of n rising edges; the first byte goes out msb first on line zero
   task automatic frame(input logic [5:0] n, input logic [7:0] op, input logic d3v);
      int i;
      d3_out = d3v;
      d0_out = op[7];
      #4 cs_n_out = 1'b0;
      for (i = 0; i < int'(n); i++) begin
         d0_out = (i < 8) ? op[7 - i] : 1'b1;
         #16 sclk_out = 1'b1;
         #16 sclk_out = 1'b0;
      end
      // deselect before the next edge could come
      #8 cs_n_out = 1'b1;
      // released lines must not keep showing their last value
      #2 d0_out = ~d0_out;
      d3_out = ~d3_out;
      // deselect time kept well above the minimum
      #100;
   endtask
   // software reset after leaving execute-in-place: enable, then reset memory
   task automatic soft_reset();
      frame(6'h08, 8'h66, 1'b1);
      frame(6'h08, 8'h99, 1'b1);
   endtask
endmodule
